// ===== tmr_pkg.sv
// Constants shared by the tone modem register port
package tmr_pkg;
   // ****************************************************************
   // Register locations and field positions
   // ****************************************************************
   localparam logic [1:0] ADDR_DIGIT = 2'h0;
   localparam logic [1:0] ADDR_MODE  = 2'h1;
   localparam logic [1:0] ADDR_SWTON = 2'h2;
   localparam logic [1:0] ADDR_OUTTX = 2'h3;
   localparam logic [3:0] REG_RESET  = 4'h0;
   localparam int MODE_LSB      = 0;
   localparam int MODE_MSB      = 2;
   localparam int BIT_DTMF_IN   = 3;
   localparam int BIT_TERM_SW   = 3;
   localparam int BIT_MODEM_IN  = 2;
   localparam int BIT_CPT_TX    = 1;
   localparam int BIT_CPT_HIGH  = 0;
   localparam int BIT_LINE_OUT  = 3;
   localparam int BIT_TERM_OUT  = 2;
   localparam int BIT_TX_EN     = 1;
   localparam int BIT_ATTEN     = 0;
   // ****************************************************************
   // Operating modes
   // ****************************************************************
   localparam logic [2:0] MODE_MODEM_TX = 3'h0;
   localparam logic [2:0] MODE_MODEM_RX = 3'h1;
   localparam logic [2:0] MODE_TONE1    = 3'h2;
   localparam logic [2:0] MODE_TONE2    = 3'h3;
   localparam logic [2:0] MODE_TONE3    = 3'h4;
   localparam logic [2:0] MODE_LOOP     = 3'h5;
   localparam logic [2:0] MODE_TEST     = 3'h6;
   localparam logic [2:0] MODE_PWRDN    = 3'h7;
   // ****************************************************************
   // Tone frequencies in Hz
   // ****************************************************************
   localparam logic [11:0] ROW_697  = 12'h2b9;
   localparam logic [11:0] ROW_770  = 12'h302;
   localparam logic [11:0] ROW_852  = 12'h354;
   localparam logic [11:0] ROW_941  = 12'h3ad;
   localparam logic [11:0] COL_1209 = 12'h4b9;
   localparam logic [11:0] COL_1336 = 12'h538;
   localparam logic [11:0] COL_1477 = 12'h5c5;
   localparam logic [11:0] COL_1633 = 12'h661;
endpackage

// ===== tmr_func_if.sv
// Control and enable signals between the register port and its decoder
`timescale 1ns/1ps
`default_nettype none
interface tmr_func_if;
   logic [2:0]  mode;
   logic        tx_en;
   logic        line_sel;
   logic [3:0]  tone_digit;
   logic        mod_en;
   logic        demod_en;
   logic        dtmf_tx_en;
   logic        dtmf_rx_en;
   logic        cpt_tx_en;
   logic        cpt_rx_en;
   logic        test_mode;
   logic        modem_tx_on;
   logic        dtmf_tone_on;
   logic [11:0] row_hz;
   logic [11:0] col_hz;
   modport ctl (output mode, tx_en, line_sel, tone_digit,
                input mod_en, demod_en, dtmf_tx_en, dtmf_rx_en,
                cpt_tx_en, cpt_rx_en, test_mode, modem_tx_on,
                dtmf_tone_on, row_hz, col_hz);
   modport dec (input mode, tx_en, line_sel, tone_digit,
                output mod_en, demod_en, dtmf_tx_en, dtmf_rx_en,
                cpt_tx_en, cpt_rx_en, test_mode, modem_tx_on,
                dtmf_tone_on, row_hz, col_hz);
endinterface
`default_nettype wire

// ===== tmr_mode_dec.sv
// Mode decoder: per-unit enables and DTMF tone pair lookup
`timescale 1ns/1ps
`default_nettype none
module tmr_mode_dec (
   input  wire logic clk,
   input  wire logic resetn,
   tmr_func_if.dec   f
);
   import tmr_pkg::*;

   typedef struct packed {
      logic [5:0]  unit_en;
      logic        test;
      logic        mtx_on;
      logic        dtx_on;
      logic [11:0] row;
      logic [11:0] col;
   } tmr_dec_t;

   tmr_dec_t st_ff;
   tmr_dec_t nxt_st;

   // ****************************************************************
   // Decode
   // ****************************************************************
   // Unit order: mod, demod, dtmf tx, dtmf rx, cpt tx, cpt rx
   always_comb begin
      nxt_st = st_ff;
      nxt_st.test = 1'b0;
      case (f.mode)
         MODE_MODEM_TX: nxt_st.unit_en = 6'h22;
         MODE_MODEM_RX: nxt_st.unit_en = 6'h12;
         MODE_TONE1:    nxt_st.unit_en = 6'h06;
         MODE_TONE2:    nxt_st.unit_en = 6'h0f;
         MODE_TONE3:    nxt_st.unit_en = 6'h0f;
         MODE_LOOP:     nxt_st.unit_en = 6'h3c;
         MODE_TEST: begin
            nxt_st.unit_en = 6'h00;
            nxt_st.test = 1'b1;
         end
         default:       nxt_st.unit_en = 6'h00;
      endcase
      // In loopback the line path picks modem or DTMF transmit
      nxt_st.mtx_on = nxt_st.unit_en[5] & f.tx_en
         & ((f.mode != MODE_LOOP) | f.line_sel);
      nxt_st.dtx_on = nxt_st.unit_en[3] & f.tx_en
         & ((f.mode != MODE_LOOP) | ~f.line_sel);
      case (f.tone_digit)
         4'h1, 4'h2, 4'h3, 4'hd: nxt_st.row = ROW_697;
         4'h4, 4'h5, 4'h6, 4'he: nxt_st.row = ROW_770;
         4'h7, 4'h8, 4'h9, 4'hf: nxt_st.row = ROW_852;
         default:                nxt_st.row = ROW_941;
      endcase
      case (f.tone_digit)
         4'h1, 4'h4, 4'h7, 4'hb: nxt_st.col = COL_1209;
         4'h2, 4'h5, 4'h8, 4'ha: nxt_st.col = COL_1336;
         4'h3, 4'h6, 4'h9, 4'hc: nxt_st.col = COL_1477;
         default:                nxt_st.col = COL_1633;
      endcase
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign f.mod_en       = st_ff.unit_en[5];
   assign f.demod_en     = st_ff.unit_en[4];
   assign f.dtmf_tx_en   = st_ff.unit_en[3];
   assign f.dtmf_rx_en   = st_ff.unit_en[2];
   assign f.cpt_tx_en    = st_ff.unit_en[1];
   assign f.cpt_rx_en    = st_ff.unit_en[0];
   assign f.test_mode    = st_ff.test;
   assign f.modem_tx_on  = st_ff.mtx_on;
   assign f.dtmf_tone_on = st_ff.dtx_on;
   assign f.row_hz       = st_ff.row;
   assign f.col_hz       = st_ff.col;

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   pwrdn_off_a: assert property (f.mode == MODE_PWRDN |=>
      st_ff.unit_en == 6'h00 && !st_ff.mtx_on && !st_ff.dtx_on)
      else $error("unit left on in power-down");
   loop_units_a: assert property (f.mode == MODE_LOOP |=>
      st_ff.unit_en == 6'h3c)
      else $error("loopback enables wrong");
   tone1_units_a: assert property (f.mode == MODE_TONE1 |=>
      f.dtmf_rx_en && f.cpt_tx_en && !f.dtmf_tx_en && !f.cpt_rx_en)
      else $error("tone 1 enables wrong");
   digit_d_a: assert property (f.tone_digit == 4'h0 |=>
      st_ff.row == ROW_941 && st_ff.col == COL_1633)
      else $error("digit D tone pair wrong");
   digit_star_a: assert property (f.tone_digit == 4'hb |=>
      st_ff.row == ROW_941 && st_ff.col == COL_1209)
      else $error("star tone pair wrong");
endmodule
`default_nettype wire

// ===== tmr_regport.sv
// Host register port of the tone and FSK modem device
`timescale 1ns/1ps
`default_nettype none
module tmr_regport (
   input  wire logic        clk,
   input  wire logic        resetn,
   input  wire logic        host_cs_n,
   input  wire logic        host_wr_n,
   input  wire logic        host_rd_n,
   input  wire logic        addr_bit1,
   input  wire logic        addr_bit0,
   input  wire logic [3:0]  host_data_in,
   output logic [3:0]       host_data_out,
   output logic             host_data_oe,
   input  wire logic        rx_digit_valid,
   input  wire logic [3:0]  rx_digit_code,
   input  wire logic        modem_tx_data,
   input  wire logic        demod_rx_data,
   output logic             modem_rx_data,
   output logic             dtmf_input_select,
   output logic             modem_input_select,
   output logic             termination_switch,
   output logic             terminal_output_select,
   output logic             line_output_select,
   output logic             progress_tone_tx_enable,
   output logic             progress_tone_high_freq,
   output logic             dtmf_attenuate,
   output logic             mod_enable,
   output logic             demod_enable,
   output logic             dtmf_tx_enable,
   output logic             dtmf_rx_enable,
   output logic             cpt_tx_enable,
   output logic             cpt_rx_enable,
   output logic             test_mode,
   output logic             modem_tx_on,
   output logic             dtmf_tone_on,
   output logic [11:0]      dtmf_row_hz,
   output logic [11:0]      dtmf_col_hz
);
   import tmr_pkg::*;

   // Pins: cs, wr, rd, a1, a0, d3..d0, txd
   localparam int PW = 10;

   typedef struct packed {
      logic [PW-1:0] sync1;
      logic [PW-1:0] sync2;
      logic          wrn_d;
      logic [3:0]    tx_digit;
      logic [3:0]    rx_digit;
      logic [3:0]    ctl_mode;
      logic [3:0]    ctl_swton;
      logic [3:0]    ctl_outtx;
      logic [3:0]    tone_digit;
      logic          ten_d;
      logic [3:0]    rd_data;
      logic          rx_bit;
   } tmr_port_t;

   tmr_port_t st_ff;
   tmr_port_t nxt_st;
   logic       cs_n_s;
   logic       wr_n_s;
   logic       rd_n_s;
   logic [1:0] addr_s;
   logic [3:0] data_s;
   logic       txd_s;
   logic       wr_take;
   logic       ten_rise;
   logic       dtmf_cap_mode;
   logic       loop_dtmf;
   logic       pd_entry;

   tmr_func_if fif ();

   tmr_mode_dec u_dec (
      .clk    (clk),
      .resetn (resetn),
      .f      (fif.dec)
   );

   // ****************************************************************
   // Host strobe decode
   // ****************************************************************
   // Only the second sync stage is decoded, so a metastable first stage is never used
   assign {cs_n_s, wr_n_s, rd_n_s, addr_s, data_s, txd_s} = st_ff.sync2;
   // Write is taken on the trailing edge, where data is settled
   assign wr_take = wr_n_s & ~st_ff.wrn_d & ~cs_n_s;
   assign ten_rise = st_ff.ctl_outtx[BIT_TX_EN] & ~st_ff.ten_d;
   assign dtmf_cap_mode = (st_ff.ctl_mode[MODE_MSB:MODE_LSB] == MODE_TONE2)
      | (st_ff.ctl_mode[MODE_MSB:MODE_LSB] == MODE_TONE3)
      | ((st_ff.ctl_mode[MODE_MSB:MODE_LSB] == MODE_LOOP)
         & ~st_ff.ctl_outtx[BIT_LINE_OUT]);
   assign loop_dtmf = (st_ff.ctl_mode[MODE_MSB:MODE_LSB] == MODE_LOOP)
      & st_ff.ctl_outtx[BIT_TX_EN] & ~st_ff.ctl_outtx[BIT_LINE_OUT];
   assign pd_entry = wr_take & (addr_s == ADDR_MODE)
      & (data_s[MODE_MSB:MODE_LSB] == MODE_PWRDN)
      & (st_ff.ctl_mode[MODE_MSB:MODE_LSB] != MODE_PWRDN);

   // ****************************************************************
   // Next state
   // ****************************************************************
   always_comb begin
      nxt_st = st_ff;
      nxt_st.sync1 = {host_cs_n, host_wr_n, host_rd_n, addr_bit1,
                      addr_bit0, host_data_in, modem_tx_data};
      nxt_st.sync2 = st_ff.sync1;
      nxt_st.wrn_d = wr_n_s;
      nxt_st.ten_d = st_ff.ctl_outtx[BIT_TX_EN];
      if (ten_rise && dtmf_cap_mode) begin
         nxt_st.tone_digit = st_ff.tx_digit;
      end
      if (loop_dtmf) begin
         nxt_st.rx_digit = st_ff.tone_digit;
      end else if (rx_digit_valid) begin
         nxt_st.rx_digit = rx_digit_code;
      end
      if (wr_take) begin
         case (addr_s)
            ADDR_DIGIT: nxt_st.tx_digit  = data_s;
            ADDR_MODE:  nxt_st.ctl_mode  = data_s;
            ADDR_SWTON: nxt_st.ctl_swton = data_s;
            ADDR_OUTTX: nxt_st.ctl_outtx = data_s;
            default:    nxt_st.tx_digit  = st_ff.tx_digit;
         endcase
      end
      if (pd_entry) begin
         nxt_st.tx_digit   = REG_RESET;
         nxt_st.rx_digit   = REG_RESET;
         nxt_st.ctl_swton  = REG_RESET;
         nxt_st.ctl_outtx  = REG_RESET;
         nxt_st.tone_digit = REG_RESET;
      end
      case (addr_s)
         ADDR_DIGIT: nxt_st.rd_data = st_ff.rx_digit;
         ADDR_MODE:  nxt_st.rd_data = st_ff.ctl_mode;
         ADDR_SWTON: nxt_st.rd_data = st_ff.ctl_swton;
         ADDR_OUTTX: nxt_st.rd_data = st_ff.ctl_outtx;
         default:    nxt_st.rd_data = REG_RESET;
      endcase
      nxt_st.rx_bit = ((st_ff.ctl_mode[MODE_MSB:MODE_LSB] == MODE_LOOP)
         & st_ff.ctl_outtx[BIT_TX_EN] & st_ff.ctl_outtx[BIT_LINE_OUT])
         ? txd_s : demod_rx_data;
   end

   // Reset clears every control bit; power-down entry clears all but the mode register
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         st_ff <= '0;
         st_ff.sync1 <= '1;
         st_ff.sync2 <= '1;
         st_ff.wrn_d <= 1'b1;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   assign fif.mode       = st_ff.ctl_mode[MODE_MSB:MODE_LSB];
   assign fif.tx_en      = st_ff.ctl_outtx[BIT_TX_EN];
   assign fif.line_sel   = st_ff.ctl_outtx[BIT_LINE_OUT];
   assign fif.tone_digit = st_ff.tone_digit;

   assign host_data_out           = st_ff.rd_data;
   assign host_data_oe            = ~rd_n_s & ~cs_n_s;
   assign modem_rx_data           = st_ff.rx_bit;
   assign dtmf_input_select       = st_ff.ctl_mode[BIT_DTMF_IN];
   assign modem_input_select      = st_ff.ctl_swton[BIT_MODEM_IN];
   assign termination_switch      = st_ff.ctl_swton[BIT_TERM_SW];
   assign progress_tone_tx_enable = st_ff.ctl_swton[BIT_CPT_TX];
   assign progress_tone_high_freq = st_ff.ctl_swton[BIT_CPT_HIGH];
   assign line_output_select      = st_ff.ctl_outtx[BIT_LINE_OUT];
   assign terminal_output_select  = st_ff.ctl_outtx[BIT_TERM_OUT];
   assign dtmf_attenuate          = st_ff.ctl_outtx[BIT_ATTEN];
   assign mod_enable              = fif.mod_en;
   assign demod_enable            = fif.demod_en;
   assign dtmf_tx_enable          = fif.dtmf_tx_en;
   assign dtmf_rx_enable          = fif.dtmf_rx_en;
   assign cpt_tx_enable           = fif.cpt_tx_en;
   assign cpt_rx_enable           = fif.cpt_rx_en;
   assign test_mode               = fif.test_mode;
   assign modem_tx_on             = fif.modem_tx_on;
   assign dtmf_tone_on            = fif.dtmf_tone_on;
   assign dtmf_row_hz             = fif.row_hz;
   assign dtmf_col_hz             = fif.col_hz;

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   sequence wr_to(logic [1:0] a);
      wr_take && addr_s == a && !pd_entry;
   endsequence

   tx_load_a: assert property (wr_to(ADDR_DIGIT) |=>
      st_ff.tx_digit == $past(data_s))
      else $error("transmit digit not loaded");
   ctl_back_a: assert property (wr_to(ADDR_SWTON) ##1
      (!wr_take && addr_s == ADDR_SWTON) |=>
      host_data_out == $past(data_s, 2))
      else $error("control readback wrong");
   rx_read_a: assert property (addr_s == ADDR_DIGIT |=>
      host_data_out == $past(st_ff.rx_digit))
      else $error("location zero read not receive digit");
   rx_keep_a: assert property (wr_take && addr_s == ADDR_DIGIT
      && !pd_entry && !rx_digit_valid && !loop_dtmf
      |=> $stable(st_ff.rx_digit))
      else $error("receive digit altered by write");
   tone_hold_a: assert property (st_ff.ten_d
      && st_ff.ctl_outtx[BIT_TX_EN] && !pd_entry
      |=> $stable(st_ff.tone_digit))
      else $error("tone digit changed during transmit");
   capture_a: assert property (ten_rise && dtmf_cap_mode && !pd_entry
      |=> st_ff.tone_digit == $past(st_ff.tx_digit))
      else $error("digit not latched on enable rise");
   pd_clear_a: assert property (pd_entry |=>
      st_ff.ctl_swton == REG_RESET && st_ff.ctl_outtx == REG_RESET
      && st_ff.ctl_mode == $past(data_s))
      else $error("power-down entry clear wrong");
   loop_dtmf_a: assert property (loop_dtmf && !pd_entry |=>
      st_ff.rx_digit == $past(st_ff.tone_digit))
      else $error("loopback digit not returned");
endmodule
`default_nettype wire

// ===== tmr_host.sv
// Host processor model driving the parallel register pins
`timescale 1ns/1ps
`default_nettype none
module tmr_host (
   input  wire logic       clk,
   output var  logic       cs_n,
   output var  logic       wr_n,
   output var  logic       rd_n,
   output var  logic       a1,
   output var  logic       a0,
   output var  logic [3:0] din,
   input  wire logic [3:0] dout,
   input  wire logic       oe
);
   initial begin
      cs_n = 1'b1;
      wr_n = 1'b1;
      rd_n = 1'b1;
      {a1, a0} = 2'h0;
      din = 4'h0;
   end
   // ****************************************************************
   // Bus cycles
   // ****************************************************************
   // Write strobe held three cycles: the pins pass a two-flop synchroniser
   task automatic wr(input logic [1:0] a, input logic [3:0] d);
      @(posedge clk);
      cs_n <= 1'b0;
      wr_n <= 1'b0;
      {a1, a0} <= a;
      din <= d;
      repeat (3) @(posedge clk);
      wr_n <= 1'b1;
      repeat (3) @(posedge clk);
      cs_n <= 1'b1;
      din <= ~d; // Released bus shows no stale value
      repeat (4) @(posedge clk);
   endtask
   task automatic rd(input logic [1:0] a, output logic [3:0] d);
      int n;
      @(posedge clk);
      cs_n <= 1'b0;
      rd_n <= 1'b0;
      {a1, a0} <= a;
      n = 0;
      // Sampled between edges, where the registered outputs are settled
      do begin
         @(negedge clk);
         n++;
      end while (oe !== 1'b1 && n < 16);
      repeat (2) @(negedge clk);
      // A read that never enabled the bus returns unknown data
      d = (oe === 1'b1) ? dout : 4'hx;
      @(posedge clk);
      cs_n <= 1'b1;
      rd_n <= 1'b1;
      repeat (3) @(posedge clk);
   endtask
endmodule
`default_nettype wire

// ===== tone_modem_host_register_port_bench.sv
// Self-checking bench of the tone modem register port
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
   err_count++; $display("mismatch %s exp %0h got %0h", n, e, g); end end
module tone_modem_host_register_port_bench;
   import tmr_pkg::*;
   logic        clk = 1'b0;
   logic        resetn = 1'b0;
   logic        cs_n, wr_n, rd_n, a1, a0, oe, rxv, mtx, demod, mrx;
   logic [3:0]  din, dout, rxc;
   logic [6:0]  en;
   logic [7:0]  sw;
   logic [1:0]  txon;
   logic [11:0] row, col;
   logic [31:0] seed = 32'h32df;
   int          err_count = 0;
   int          samples_checked = 0;
   int          cyc = 0;
   int          m[4] = '{0, 0, 0, 0};
   int          rxd = 0;
   int          tone = 0;
   // Enables per mode: mod, demod, dtmf tx, dtmf rx, cpt tx, cpt rx, test
   int          en_tab[8] = '{7'h44, 7'h24, 7'h0c, 7'h1e, 7'h1e, 7'h78,
                              7'h01, 7'h00};
   always #2.5 clk = ~clk;
   tmr_host host (.clk(clk), .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n),
      .a1(a1), .a0(a0), .din(din), .dout(dout), .oe(oe));
   tmr_regport dut (.clk(clk), .resetn(resetn), .host_cs_n(cs_n),
      .host_wr_n(wr_n), .host_rd_n(rd_n), .addr_bit1(a1), .addr_bit0(a0),
      .host_data_in(din), .host_data_out(dout), .host_data_oe(oe),
      .rx_digit_valid(rxv), .rx_digit_code(rxc), .modem_tx_data(mtx),
      .demod_rx_data(demod), .modem_rx_data(mrx),
      .dtmf_input_select(sw[7]), .termination_switch(sw[6]),
      .modem_input_select(sw[5]), .progress_tone_tx_enable(sw[4]),
      .progress_tone_high_freq(sw[3]), .line_output_select(sw[2]),
      .terminal_output_select(sw[1]), .dtmf_attenuate(sw[0]),
      .mod_enable(en[6]), .demod_enable(en[5]), .dtmf_tx_enable(en[4]),
      .dtmf_rx_enable(en[3]), .cpt_tx_enable(en[2]), .cpt_rx_enable(en[1]),
      .test_mode(en[0]), .modem_tx_on(txon[1]), .dtmf_tone_on(txon[0]),
      .dtmf_row_hz(row), .dtmf_col_hz(col));
   initial begin
      rxv = 1'b0;
      rxc = 4'h0;
      mtx = 1'b0;
      demod = 1'b0;
   end
   // ****************************************************************
   // Reference model
   // ****************************************************************
   function automatic logic [3:0] rnd4();
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed[3:0];
   endfunction
   function automatic int rowhz(int c);
      case (c)
         1, 2, 3, 13: return 697;
         4, 5, 6, 14: return 770;
         7, 8, 9, 15: return 852;
         default: return 941;
      endcase
   endfunction
   function automatic int colhz(int c);
      case (c)
         0, 13, 14, 15: return 1633;
         1, 4, 7, 11: return 1209;
         2, 5, 8, 10: return 1336;
         default: return 1477;
      endcase
   endfunction
   task automatic mwr(int a, int d);
      int md;
      md = m[1] & 7;
      if (a == 1 && (d & 7) == 7 && md != 7) begin
         m = '{0, 0, 0, 0};
         rxd = 0;
         tone = 0;
      end
      if (a == 3 && !m[3][1] && d[1] && (md == 3 || md == 4 ||
          (md == 5 && !d[3])))
         tone = m[0];
      m[a] = d;
      if ((m[1] & 7) == 5 && m[3][1] && !m[3][3])
         rxd = tone;
      host.wr(a[1:0], d[3:0]);
   endtask
   task automatic chk_all();
      logic [3:0] d;
      int md;
      bit lp;
      md = m[1] & 7;
      lp = m[3][3];
      for (int a = 0; a < 4; a++) begin
         host.rd(a[1:0], d);
         `CHK("reg", 4'((a == 0) ? rxd : m[a]), d)
      end
      `CHK("oe idle", 1'b0, oe)
      `CHK("enables", 7'(en_tab[md]), en)
      `CHK("switches", 8'({m[1][3], m[2][3:0], m[3][3:2], m[3][0]}), sw)
      `CHK("row", 12'(rowhz(tone)), row)
      `CHK("col", 12'(colhz(tone)), col)
      `CHK("tx on", {m[3][1] && (md == 0 || (md == 5 && lp)),
         m[3][1] && (md == 3 || md == 4 || (md == 5 && !lp))}, txon)
   endtask
   // ****************************************************************
   // Verdict and hang guard
   // ****************************************************************
   task automatic report_and_stop();
      if (err_count == 0 && samples_checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 40000) begin
         err_count++;
         report_and_stop();
      end
   end
   // ****************************************************************
   // Scenarios
   // ****************************************************************
   initial begin
      repeat (16) @(posedge clk);
      resetn <= 1'b1;
      mwr(1, 7);
      chk_all();
      for (int md = 0; md < 7; md++) begin
         mwr(1, md | (rnd4() & 8));
         chk_all();
      end
      // Transmit enable kept low here so tone latching stays directed
      repeat (12) begin
         mwr(2, rnd4());
         mwr(3, rnd4() & 13);
         mwr(1, rnd4());
         chk_all();
      end
      for (int c = 0; c < 16; c++) begin
         mwr(1, 3 + (c & 1));
         mwr(0, c);
         mwr(3, 2);
         chk_all();
         mwr(0, 15 - c);
         chk_all();
         mwr(3, 0);
      end
      mwr(1, 5);
      mwr(0, 9);
      mwr(3, 2);
      chk_all();
      mwr(3, 0);
      mwr(3, 10);
      chk_all();
      repeat (4) begin
         @(posedge clk);
         mtx <= rnd4() & 1;
         repeat (6) @(posedge clk);
         `CHK("loop data", mtx, mrx)
      end
      mwr(3, 0);
      mwr(1, 2);
      @(posedge clk);
      rxv <= 1'b1;
      rxc <= 4'h5;
      @(posedge clk);
      rxv <= 1'b0;
      rxc <= 4'ha;
      rxd = 5;
      chk_all();
      mwr(0, 3);
      chk_all();
      repeat (2) begin
         @(posedge clk);
         demod <= ~demod;
         repeat (6) @(posedge clk);
         `CHK("rx data", demod, mrx)
      end
      mwr(2, 15);
      mwr(1, 15);
      chk_all();
      report_and_stop();
   end
endmodule
`default_nettype wire
